// >>> core/ecm_pkg.sv
package ecm_pkg;

  // Register addresses as carried on the serial link.
  localparam logic [15:0] ADDR_HOURS_HI    = 16'h9C41;
  localparam logic [15:0] ADDR_HOURS_LO    = 16'h9C42;
  localparam logic [15:0] ADDR_SPEED       = 16'h9C43;
  localparam logic [15:0] ADDR_VOLTAGE     = 16'h9C44;
  localparam logic [15:0] ADDR_OIL_PRESS   = 16'h9C45;
  localparam logic [15:0] ADDR_ENG_TEMP    = 16'h9C46;
  localparam logic [15:0] ADDR_SEQ_STATE   = 16'h9C47;
  localparam logic [15:0] ADDR_SHUTDOWN_A  = 16'h9C48;
  localparam logic [15:0] ADDR_SHUTDOWN_B  = 16'h9C49;
  localparam logic [15:0] ADDR_SHUTDOWN_C  = 16'h9C4A;
  localparam logic [15:0] ADDR_LEVEL       = 16'h9C4B;
  localparam logic [15:0] ADDR_START_STOP  = 16'h9C4C;
  localparam logic [15:0] ADDR_MAX_SPEED   = 16'h9C4D;
  localparam logic [15:0] ADDR_AMB_TEMP    = 16'h9C4E;
  localparam logic [15:0] ADDR_MODE        = 16'h9C4F;
  localparam logic [15:0] ADDR_LOAD_SPEED  = 16'h9C50;
  localparam logic [15:0] ADDR_MANUAL_ONLY = 16'h9C51;
  localparam logic [15:0] ADDR_PRE1_AUTO   = 16'h9C52;
  localparam logic [15:0] ADDR_PRE2_AUTO   = 16'h9C53;
  localparam logic [15:0] ADDR_COMMIT      = 16'h9D30;

  // Slots of the writable words, both in the working copy and in the saved store.
  localparam logic [2:0] IX_START_STOP  = 3'h0;
  localparam logic [2:0] IX_MAX_SPEED   = 3'h1;
  localparam logic [2:0] IX_MODE        = 3'h2;
  localparam logic [2:0] IX_LOAD_SPEED  = 3'h3;
  localparam logic [2:0] IX_MANUAL_ONLY = 3'h4;
  localparam logic [2:0] IX_PRE1_AUTO   = 3'h5;
  localparam logic [2:0] IX_PRE2_AUTO   = 3'h6;
  localparam logic [2:0] IX_LAST        = 3'h6;

  localparam logic [15:0] COMMIT_KEY     = 16'h0001;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [7:0]  NODE_ID_RST    = 8'h01;
  localparam logic [15:0] SHUTDOWN_A_MSK = 16'h8FFF;
  localparam logic [15:0] SHUTDOWN_B_MSK = 16'hB99F;
  localparam logic [15:0] SHUTDOWN_C_MSK = 16'h0001;

  typedef enum logic [4:0] {
    SEQ_ECU_SETTLE   = 5'h00,
    SEQ_STOPPED      = 5'h01,
    SEQ_STANDBY      = 5'h02,
    SEQ_PRESTART1    = 5'h03,
    SEQ_SAFE_CHECK   = 5'h04,
    SEQ_PRESTART2    = 5'h05,
    SEQ_CRANKING     = 5'h06,
    SEQ_CRANK_REST   = 5'h07,
    SEQ_FALSE_START  = 5'h08,
    SEQ_WARMUP       = 5'h09,
    SEQ_LINE_FILL1   = 5'h0A,
    SEQ_LINE_FILL2   = 5'h0B,
    SEQ_RUN_LOADED   = 5'h0C,
    SEQ_COOLDOWN     = 5'h0D,
    SEQ_ENERGIZE_OFF = 5'h0E,
    SEQ_SPINDOWN     = 5'h0F,
    SEQ_WAIT_START   = 5'h10
  } ecm_seq_state_t;

  typedef enum logic [1:0] {
    ST_LOAD_A = 2'b00,
    ST_LOAD_B = 2'b01,
    ST_IDLE   = 2'b11,
    ST_COMMIT = 2'b10
  } ecm_ctl_state_t;

endpackage

// >>> core/ecm_store_if.sv
`timescale 1ns/1ps
interface ecm_store_if;
  logic        we;
  logic [2:0]  waddr;
  logic [15:0] wdata;
  logic [2:0]  raddr;
  logic [15:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> core/ecm_store.sv
`timescale 1ns/1ps
module ecm_store
  import ecm_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  ecm_store_if.mem  port
);

  // The array is never reset: it stands for storage that outlives a power cycle.
  logic [15:0] mem [0:7];
  logic [15:0] rdata_q;

  always_ff @(posedge mclk_i) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= WORD_RST;
    end else begin
      rdata_q <= mem[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule // ecm_store

// >>> core/ecm_regs.sv
`timescale 1ns/1ps
// Contract
// - Link writes change only working copies; reset restores the saved values.
// - Writing one to the commit register saves all working copies permanently.
// - Run hours read as a 32-bit value over two consecutive words.
// - Supply voltage reads in tenths of a volt.
// - Sequencer state reads as numbers 0 to 8 for the early states.
// - Sequencer state numbers continue from 9 to 16.
// - Shutdown flag bits read one while the fault is active.
// - First shutdown word carries speed, crank, oil, fuel, pressure and remote faults.
// - Second shutdown word carries level, flow, fuel water, suction, gearbox, lamp.
// - Third shutdown word uses bit zero for pivot alignment only.
// - System level reads in tenths of a foot.
// - Start word one starts, zero stops, acting only in automatic mode.
// - Maximum speed setpoint is a writable word in rpm.
// - Mode word: zero manual, one automatic.
// - Manual-only option word: one enables, zero disables.
// - Each prestart word: one auto starts only, zero both kinds.
// - Loaded running speed setpoint is a writable word in rpm.
// - Speed, oil pressure and both temperatures read as plain measurements.
// - The slave node number is settable and starts at one.
module ecm_regs
  import ecm_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           resetn_i,
  input  wire logic           req_i,
  input  wire logic           req_we_i,
  input  wire logic [15:0]    req_addr_i,
  input  wire logic [15:0]    req_wdata_i,
  output logic                ready_o,
  output logic                ack_o,
  output logic                err_o,
  output logic [15:0]         rdata_o,
  input  wire logic           panel_we_i,
  input  wire logic [2:0]     panel_sel_i,
  input  wire logic [15:0]    panel_data_i,
  input  wire logic           panel_node_we_i,
  input  wire logic [7:0]     panel_node_i,
  input  wire logic [31:0]    run_hours_i,
  input  wire logic [15:0]    engine_speed_i,
  input  wire logic [15:0]    supply_voltage_i,
  input  wire logic [15:0]    oil_pressure_i,
  input  wire logic [15:0]    engine_temp_i,
  input  wire logic [15:0]    ambient_temp_i,
  input  wire logic [15:0]    system_level_i,
  input  wire ecm_seq_state_t seq_state_i,
  input  wire logic [15:0]    shutdown_a_i,
  input  wire logic [15:0]    shutdown_b_i,
  input  wire logic [15:0]    shutdown_c_i,
  output logic                engine_run_cmd_o,
  output logic                auto_mode_o,
  output logic [15:0]         max_speed_o,
  output logic [15:0]         loaded_speed_o,
  output logic                manual_only_o,
  output logic                pre1_auto_o,
  output logic                pre2_auto_o,
  output logic [7:0]          node_id_o
);

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    ecm_ctl_state_t   st;
    logic [2:0]       idx;
    logic [6:0][15:0] wk;
    logic [15:0]      rdata;
    logic             ack;
    logic             err;
    logic             ready;
    logic             run_cmd;
    logic [7:0]       node;
  } ecm_core_t;

  localparam ecm_core_t CORE_RST = '{
    st:      ST_LOAD_A,
    idx:     3'h0,
    wk:      '0,
    rdata:   WORD_RST,
    ack:     1'b0,
    err:     1'b0,
    ready:   1'b0,
    run_cmd: 1'b0,
    node:    NODE_ID_RST
  };

  ecm_core_t   q;
  ecm_core_t   d;
  ecm_store_if store ();

  ecm_store u_store (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .port     (store.mem)
  );

  // Flag words keep only their single-bit meaning; the rest of the word reads zero.
  function automatic logic [15:0] ecm_clean(input logic [2:0] ix, input logic [15:0] v);
    if (ix == IX_MAX_SPEED || ix == IX_LOAD_SPEED) begin
      return v;
    end
    return {15'h0000, v[0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  logic [15:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = WORD_RST;
    unique case (req_addr_i)
      ADDR_HOURS_HI:    rd_word = run_hours_i[31:16];
      ADDR_HOURS_LO:    rd_word = run_hours_i[15:0];
      ADDR_SPEED:       rd_word = engine_speed_i;
      ADDR_VOLTAGE:     rd_word = supply_voltage_i;
      ADDR_OIL_PRESS:   rd_word = oil_pressure_i;
      ADDR_ENG_TEMP:    rd_word = engine_temp_i;
      ADDR_SEQ_STATE:   rd_word = {11'h000, seq_state_i};
      ADDR_SHUTDOWN_A:  rd_word = shutdown_a_i & SHUTDOWN_A_MSK;
      ADDR_SHUTDOWN_B:  rd_word = shutdown_b_i & SHUTDOWN_B_MSK;
      ADDR_SHUTDOWN_C:  rd_word = shutdown_c_i & SHUTDOWN_C_MSK;
      ADDR_LEVEL:       rd_word = system_level_i;
      ADDR_START_STOP:  rd_word = q.wk[IX_START_STOP];
      ADDR_MAX_SPEED:   rd_word = q.wk[IX_MAX_SPEED];
      ADDR_AMB_TEMP:    rd_word = ambient_temp_i;
      ADDR_MODE:        rd_word = q.wk[IX_MODE];
      ADDR_LOAD_SPEED:  rd_word = q.wk[IX_LOAD_SPEED];
      ADDR_MANUAL_ONLY: rd_word = q.wk[IX_MANUAL_ONLY];
      ADDR_PRE1_AUTO:   rd_word = q.wk[IX_PRE1_AUTO];
      ADDR_PRE2_AUTO:   rd_word = q.wk[IX_PRE2_AUTO];
      ADDR_COMMIT:      rd_word = WORD_RST;
      default:          rd_hit  = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////

  logic [2:0] wr_ix;
  logic       wr_hit;

  always_comb begin
    wr_hit = 1'b1;
    wr_ix  = IX_START_STOP;
    unique case (req_addr_i)
      ADDR_START_STOP:  wr_ix = IX_START_STOP;
      ADDR_MAX_SPEED:   wr_ix = IX_MAX_SPEED;
      ADDR_MODE:        wr_ix = IX_MODE;
      ADDR_LOAD_SPEED:  wr_ix = IX_LOAD_SPEED;
      ADDR_MANUAL_ONLY: wr_ix = IX_MANUAL_ONLY;
      ADDR_PRE1_AUTO:   wr_ix = IX_PRE1_AUTO;
      ADDR_PRE2_AUTO:   wr_ix = IX_PRE2_AUTO;
      default:          wr_hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d           = q;
    d.ack       = 1'b0;
    d.err       = 1'b0;
    store.we    = 1'b0;
    store.waddr = q.idx;
    store.wdata = q.wk[q.idx];
    store.raddr = q.idx;
    unique case (q.st)
      ST_LOAD_A: begin
        d.st = ST_LOAD_B;
      end
      ST_LOAD_B: begin
        // Working copies start from the saved values after every reset.
        d.wk[q.idx] = ecm_clean(q.idx, store.rdata);
        if (q.idx == IX_LAST) begin
          d.idx   = 3'h0;
          d.st    = ST_IDLE;
          d.ready = 1'b1;
        end else begin
          d.idx = q.idx + 3'h1;
          d.st  = ST_LOAD_A;
        end
      end
      ST_IDLE: begin
        if (req_i) begin
          d.ack   = 1'b1;
          d.rdata = WORD_RST;
          if (req_we_i) begin
            if (wr_hit) begin
              d.wk[wr_ix] = ecm_clean(wr_ix, req_wdata_i);
            end else if (req_addr_i == ADDR_COMMIT) begin
              if (req_wdata_i == COMMIT_KEY) begin
                d.st    = ST_COMMIT;
                d.idx   = 3'h0;
                d.ready = 1'b0;
              end
            end else begin
              d.err = 1'b1;
            end
          end else begin
            d.rdata = rd_word;
            d.err   = !rd_hit;
          end
        end
        // Entries from the local panel are saved at once and win over the link.
        if (panel_we_i && panel_sel_i <= IX_LAST) begin
          d.wk[panel_sel_i] = ecm_clean(panel_sel_i, panel_data_i);
          store.we          = 1'b1;
          store.waddr       = panel_sel_i;
          store.wdata       = ecm_clean(panel_sel_i, panel_data_i);
        end
      end
      ST_COMMIT: begin
        store.we = 1'b1;
        if (q.idx == IX_LAST) begin
          d.idx   = 3'h0;
          d.st    = ST_IDLE;
          d.ready = 1'b1;
        end else begin
          d.idx = q.idx + 3'h1;
        end
      end
    endcase
    if (panel_node_we_i) begin
      d.node = panel_node_i;
    end
    // Start only takes effect while the mode word selects automatic operation.
    d.run_cmd = d.wk[IX_START_STOP][0] & d.wk[IX_MODE][0];
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign ready_o          = q.ready;
  assign ack_o            = q.ack;
  assign err_o            = q.err;
  assign rdata_o          = q.rdata;
  assign engine_run_cmd_o = q.run_cmd;
  assign auto_mode_o      = q.wk[IX_MODE][0];
  assign max_speed_o      = q.wk[IX_MAX_SPEED];
  assign loaded_speed_o   = q.wk[IX_LOAD_SPEED];
  assign manual_only_o    = q.wk[IX_MANUAL_ONLY][0];
  assign pre1_auto_o      = q.wk[IX_PRE1_AUTO][0];
  assign pre2_auto_o      = q.wk[IX_PRE2_AUTO][0];
  assign node_id_o        = q.node;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  logic rd_taken;
  logic wr_taken;
  assign rd_taken = req_i && !req_we_i && ready_o;
  assign wr_taken = req_i && req_we_i && ready_o;

  a_run_needs_auto: assert property (
    engine_run_cmd_o |-> auto_mode_o
  ) else $error("Run command active outside automatic mode.");

  a_voltage_read: assert property (
    rd_taken && req_addr_i == ADDR_VOLTAGE |=> ack_o && rdata_o == $past(supply_voltage_i)
  ) else $error("Voltage read returned the wrong word.");

  a_hours_split: assert property (
    rd_taken && req_addr_i == ADDR_HOURS_LO |=> rdata_o == $past(run_hours_i[15:0]) && !err_o
  ) else $error("Low run hours word read wrong.");

  a_seq_number: assert property (
    rd_taken && req_addr_i == ADDR_SEQ_STATE |=> rdata_o == {11'h000, $past(seq_state_i)}
  ) else $error("Sequencer state read wrong.");

  a_flags_b_read: assert property (
    rd_taken && req_addr_i == ADDR_SHUTDOWN_B
      |=> rdata_o == ($past(shutdown_b_i) & SHUTDOWN_B_MSK)
  ) else $error("Second shutdown word read wrong.");

  a_flags_c_resv: assert property (
    rd_taken && req_addr_i == ADDR_SHUTDOWN_C |=> rdata_o[15:1] == 15'h0000
  ) else $error("Reserved shutdown bits read nonzero.");

  a_ro_write_err: assert property (
    wr_taken && req_addr_i == ADDR_SPEED |=> ack_o && err_o
  ) else $error("Write to read-only word not refused.");

  a_mode_write: assert property (
    wr_taken && req_addr_i == ADDR_MODE && !panel_we_i
      |=> auto_mode_o == $past(req_wdata_i[0])
  ) else $error("Mode write did not take.");

  a_commit_walk: assert property (
    wr_taken && req_addr_i == ADDR_COMMIT && req_wdata_i == COMMIT_KEY
      |=> store.we [*7] ##1 ready_o
  ) else $error("Commit did not save seven words.");

  a_no_plain_save: assert property (
    store.we |-> q.st == ST_COMMIT || panel_we_i
  ) else $error("Saved store written without commit or panel.");

  // A panel entry must reach the saved store in the same cycle, or a reset would lose it.
  a_panel_saves: assert property (
    panel_we_i && ready_o && panel_sel_i <= IX_LAST
      |-> store.we && store.waddr == panel_sel_i
  ) else $error("Panel entry not saved at once.");

  a_busy_no_ack: assert property (
    req_i && !ready_o |=> !ack_o
  ) else $error("Request answered while busy.");

  a_hours_high: assert property (
    rd_taken && req_addr_i == ADDR_HOURS_HI |=> rdata_o == $past(run_hours_i[31:16]) && !err_o
  ) else $error("High run hours word read wrong.");

  a_flags_a_read: assert property (
    rd_taken && req_addr_i == ADDR_SHUTDOWN_A
      |=> rdata_o == ($past(shutdown_a_i) & SHUTDOWN_A_MSK)
  ) else $error("First shutdown word read wrong.");

  a_level_read: assert property (
    rd_taken && req_addr_i == ADDR_LEVEL |=> rdata_o == $past(system_level_i)
  ) else $error("System level read wrong.");

  a_max_write: assert property (
    wr_taken && req_addr_i == ADDR_MAX_SPEED && !panel_we_i
      |=> max_speed_o == $past(req_wdata_i)
  ) else $error("Maximum speed write did not take.");

  a_unmapped_read: assert property (
    rd_taken && !rd_hit |=> ack_o && err_o && rdata_o == WORD_RST
  ) else $error("Unmapped read not refused with zero.");

  c_commit: cover property (wr_taken && req_addr_i == ADDR_COMMIT && req_wdata_i == COMMIT_KEY);
  c_panel: cover property (panel_we_i && ready_o);
  c_reload: cover property ($rose(ready_o));
  c_run_cmd: cover property ($rose(engine_run_cmd_o));
  c_unmapped: cover property (ack_o && err_o && !$past(req_we_i));

endmodule // ecm_regs

// >>> tb/ecm_master.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Link master: holds each request until it is taken, then lets the lines wander.
module ecm_master (
  input  wire logic        mclk_i,
  input  wire logic        ready_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [15:0] rdata_i,
  output logic             req_o,
  output logic             we_o,
  output logic [15:0]      addr_o,
  output logic [15:0]      wdata_o
);
  initial begin
    req_o   = 1'b0;
    we_o    = 1'b0;
    addr_o  = 16'h0000;
    wdata_o = 16'h0000;
  end

  // Address and data are inverted once taken, so a stale value is never read as valid.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e, output logic ok);
    int n;
    n = 0;
    @(posedge mclk_i);
    #1;
    req_o   = 1'b1;
    we_o    = w;
    addr_o  = a;
    wdata_o = d;
    while (ready_i !== 1'b1 && n < 64) begin
      @(negedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    #1;
    req_o   = 1'b0;
    we_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
    @(negedge mclk_i);
    q  = rdata_i;
    e  = err_i;
    ok = (ack_i === 1'b1) && (n < 64);
  endtask
endmodule // ecm_master

// >>> tb/test_engine_controller_modbus_map.sv
`timescale 1ns/1ps
module test_engine_controller_modbus_map;
  import ecm_pkg::*;
  localparam int LIMIT = 20000;
  logic           mclk_i   = 1'b0;
  logic           resetn_i = 1'b0;
  logic           req, req_we, ready, ack, err, pwe, nwe, run, amode, monly, p1, p2;
  logic [15:0]    addr, wdata, rdata, pdata, spd, volt, oil, etmp, atmp, lvl, sda, sdb, sdc;
  logic [15:0]    maxs, lds;
  logic [2:0]     psel;
  logic [7:0]     node_in, node_id;
  logic [31:0]    hours;
  ecm_seq_state_t seq;
  int             failures, tests_run, cycles;

  always #50 mclk_i = ~mclk_i;

  ecm_regs DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req), .req_we_i(req_we),
    .req_addr_i(addr), .req_wdata_i(wdata), .ready_o(ready), .ack_o(ack), .err_o(err),
    .rdata_o(rdata), .panel_we_i(pwe), .panel_sel_i(psel), .panel_data_i(pdata),
    .panel_node_we_i(nwe), .panel_node_i(node_in), .run_hours_i(hours),
    .engine_speed_i(spd), .supply_voltage_i(volt), .oil_pressure_i(oil),
    .engine_temp_i(etmp), .ambient_temp_i(atmp), .system_level_i(lvl), .seq_state_i(seq),
    .shutdown_a_i(sda), .shutdown_b_i(sdb), .shutdown_c_i(sdc), .engine_run_cmd_o(run),
    .auto_mode_o(amode), .max_speed_o(maxs), .loaded_speed_o(lds), .manual_only_o(monly),
    .pre1_auto_o(p1), .pre2_auto_o(p2), .node_id_o(node_id));

  ecm_master u_master (.mclk_i(mclk_i), .ready_i(ready), .ack_i(ack), .err_i(err),
    .rdata_i(rdata), .req_o(req), .we_o(req_we), .addr_o(addr), .wdata_o(wdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask

  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic xe);
    logic [15:0] q;
    logic        e, ok;
    u_master.xfer(1'b0, a, 16'h0000, q, e, ok);
    chk_bit(ok, 1'b1, "no answer");
    chk_bit(e, xe, "read error flag");
    chk_word(q, x, "read data");
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic xe);
    logic [15:0] q;
    logic        e, ok;
    u_master.xfer(1'b1, a, d, q, e, ok);
    chk_bit(ok, 1'b1, "no answer");
    chk_bit(e, xe, "write error flag");
  endtask

  task automatic panel(input logic [2:0] s, input logic [15:0] d);
    int n;
    n = 0;
    tick;
    pwe   = 1'b1;
    psel  = s;
    pdata = d;
    while (ready !== 1'b1 && n < 64) begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 64) fail("panel write never taken");
    tick;
    pwe   = 1'b0;
    pdata = ~d;
  endtask

  // Ready must stay low for the whole reload of the saved words.
  task automatic do_reset;
    tick;
    resetn_i = 1'b0;
    #1;
    chk_word({8'h00, node_id}, 16'h0001, "node during reset");
    chk_bit(amode, 1'b0, "mode during reset");
    repeat (4) @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    repeat (13) tick;
    chk_bit(ready, 1'b0, "ready early");
    tick;
    chk_bit(ready, 1'b1, "ready late");
  endtask

  // Panel values: start, max speed, mode, loaded speed, manual only, prestart 1, 2.
  task automatic chk_panel_vals;
    chk_word(maxs, 16'h0BB8, "max speed");
    chk_word(lds, 16'h0708, "loaded speed");
    chk_bit(amode, 1'b0, "mode");
    chk_bit(run, 1'b0, "run in manual");
    chk_bit(monly, 1'b1, "manual only");
    chk_bit(p1, 1'b0, "prestart 1");
    chk_bit(p2, 1'b1, "prestart 2");
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail("timeout");
      summarize;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] w, m;
    logic [15:0] pv [7];
    pv = '{16'h0001, 16'h0BB8, 16'h0000, 16'h0708, 16'h0001, 16'h0000, 16'h0001};
    {pwe, nwe, psel, pdata, node_in} = '0;
    {hours, spd, volt, oil, etmp, atmp, lvl, sda, sdb, sdc} = '0;
    seq = SEQ_ECU_SETTLE;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    do_reset;
    for (int i = 0; i < 7; i++) panel(i[2:0], pv[i]);
    tick;
    chk_panel_vals;
    $display("test panel done");

    tick;
    hours = 32'h1234_5678;
    spd   = 16'h05DC;
    volt  = 16'h007D;
    oil   = 16'h0113;
    etmp  = 16'h0055;
    atmp  = 16'h0019;
    lvl   = 16'h01F9;
    rd(ADDR_HOURS_HI, 16'h1234, 1'b0);
    rd(ADDR_HOURS_LO, 16'h5678, 1'b0);
    rd(ADDR_SPEED, 16'h05DC, 1'b0);
    rd(ADDR_VOLTAGE, 16'h007D, 1'b0);
    rd(ADDR_OIL_PRESS, 16'h0113, 1'b0);
    rd(ADDR_ENG_TEMP, 16'h0055, 1'b0);
    rd(ADDR_AMB_TEMP, 16'h0019, 1'b0);
    rd(ADDR_LEVEL, 16'h01F9, 1'b0);
    for (int i = 0; i < 17; i++) begin
      tick;
      seq = ecm_seq_state_t'(i[4:0]);
      rd(ADDR_SEQ_STATE, {11'h000, i[4:0]}, 1'b0);
    end
    for (int j = 0; j < 3; j++) begin
      for (int b = 0; b < 16; b++) begin
        tick;
        w   = 16'h0001 << b;
        sda = (j == 0) ? w : 16'h0000;
        sdb = (j == 1) ? w : 16'h0000;
        sdc = (j == 2) ? w : 16'h0000;
        m   = (j == 0) ? SHUTDOWN_A_MSK : (j == 1) ? SHUTDOWN_B_MSK : SHUTDOWN_C_MSK;
        rd(ADDR_SHUTDOWN_A + 16'(j), w & m, 1'b0);
      end
    end
    $display("test measurements done");

    wr(ADDR_SPEED, 16'h1111, 1'b1);
    rd(ADDR_SPEED, 16'h05DC, 1'b0);
    rd(16'h9C54, 16'h0000, 1'b1);
    wr(16'h9C00, 16'h1111, 1'b1);
    rd(ADDR_COMMIT, 16'h0000, 1'b0);
    $display("test refusals done");

    wr(ADDR_MODE, 16'hFFFF, 1'b0);
    chk_bit(amode, 1'b1, "auto mode");
    chk_bit(run, 1'b1, "start in auto");
    rd(ADDR_MODE, 16'h0001, 1'b0);
    wr(ADDR_START_STOP, 16'h0000, 1'b0);
    chk_bit(run, 1'b0, "stop in auto");
    wr(ADDR_START_STOP, 16'h0001, 1'b0);
    wr(ADDR_MAX_SPEED, 16'h0C1C, 1'b0);
    rd(ADDR_MAX_SPEED, 16'h0C1C, 1'b0);
    wr(ADDR_LOAD_SPEED, 16'h0640, 1'b0);
    chk_word(lds, 16'h0640, "loaded speed write");
    wr(ADDR_MANUAL_ONLY, 16'h0000, 1'b0);
    wr(ADDR_PRE1_AUTO, 16'h0001, 1'b0);
    wr(ADDR_PRE2_AUTO, 16'h0000, 1'b0);
    chk_bit(monly, 1'b0, "manual only write");
    chk_bit(p1, 1'b1, "prestart 1 write");
    chk_bit(p2, 1'b0, "prestart 2 write");
    wr(ADDR_COMMIT, 16'h0002, 1'b0);
    chk_bit(ready, 1'b1, "commit key ignored");
    do_reset;
    chk_panel_vals;
    $display("test temporary writes done");

    wr(ADDR_MODE, 16'h0001, 1'b0);
    wr(ADDR_MAX_SPEED, 16'h0C1C, 1'b0);
    wr(ADDR_COMMIT, COMMIT_KEY, 1'b0);
    chk_bit(ready, 1'b0, "busy saving");
    rd(ADDR_MAX_SPEED, 16'h0C1C, 1'b0);
    do_reset;
    chk_bit(amode, 1'b1, "mode kept");
    chk_word(maxs, 16'h0C1C, "max speed kept");
    chk_bit(run, 1'b1, "start kept");
    $display("test commit done");

    tick;
    nwe     = 1'b1;
    node_in = 8'h2A;
    tick;
    nwe = 1'b0;
    chk_word({8'h00, node_id}, 16'h002A, "node number");
    $display("test node done");
    summarize;
  end
endmodule // test_engine_controller_modbus_map
